//--- shared/pps_pkg.sv
// package: register map, encodings, states and timing of the panel power sequencer
package pps_pkg;

  // register offsets on the aux register port
  localparam logic [19:0] REG_SINK_LOCK_STATUS = 20'h0_0205;
  localparam logic [19:0] REG_POWER_STATE_REQUEST = 20'h0_0600;
  localparam logic [19:0] REG_PANEL_GENERAL_CAPABILITY = 20'h0_0701;
  localparam logic [19:0] REG_PANEL_DISPLAY_CONTROL = 20'h0_0720;
  localparam logic [19:0] REG_DIMMING_LEVEL = 20'h0_0721;

  // field positions
  localparam int LOCK_BIT = 0;
  localparam int CAP_BKLT_PIN_BIT = 1;
  localparam int CAP_SET_POWER_BIT = 7;
  localparam int CTRL_BKLT_EN_BIT = 0;
  localparam int CTRL_PWM_PASS_BIT = 7;

  // power state values and reset values
  localparam logic [7:0] PWR_D0 = 8'h01;
  localparam logic [7:0] PWR_D3 = 8'h02;
  localparam logic [7:0] RST_POWER_STATE = 8'h01;
  localparam logic [7:0] RST_DISPLAY_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIMMING_LEVEL = 8'h80;
  localparam logic [7:0] RST_CAPABILITY = 8'h82;

  // bus role strap codes and i2c addresses
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [7:0] I2C_ADDR_LOW = 8'h40;
  localparam logic [7:0] I2C_ADDR_HIGH = 8'hC0;

  // timing
  localparam int CLK_MHZ = 20;
  localparam int BACKLIGHT_ON_DELAY_US = 200;
  localparam int BACKLIGHT_OFF_TO_VIDEO_OFF_DELAY_US = 50;
  localparam int VIDEO_OFF_TO_POWER_OFF_DELAY_US = 500;
  localparam int BACKLIGHT_ON_DELAY_CYC = BACKLIGHT_ON_DELAY_US * CLK_MHZ;
  localparam int BACKLIGHT_OFF_TO_VIDEO_OFF_DELAY_CYC = BACKLIGHT_OFF_TO_VIDEO_OFF_DELAY_US * CLK_MHZ;
  localparam int VIDEO_OFF_TO_POWER_OFF_DELAY_CYC = VIDEO_OFF_TO_POWER_OFF_DELAY_US * CLK_MHZ;
  localparam int TIMER_W = 20;
  localparam int PWM_W = 8;

  typedef enum logic [6:0] {
    ST_WAIT_VIDEO = 7'h01,
    ST_STREAM = 7'h02,
    ST_LIT = 7'h04,
    ST_BKLT_OFF = 7'h08,
    ST_VIDEO_OFF = 7'h10,
    ST_LOW_POWER = 7'h20,
    ST_DEEP_SLEEP = 7'h40
  } pps_state_type;

  typedef struct packed {
    logic panel_power_en;
    logic backlight_en;
    logic lvds_out_en;
    logic lvds_pulldown;
    logic main_link_hiz;
    logic hot_plug_out;
  } pps_panel_type;

  typedef struct packed {
    logic i2c_en;
    logic i2c_master;
    logic [7:0] i2c_addr;
  } pps_i2c_type;

endpackage

//--- core/pps_pwm_gen.sv
// module: free-running dimming pwm generator
`timescale 1ns/100ps
module pps_pwm_gen
  import pps_pkg::*;
#(
  parameter int WIDTH = PWM_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic [WIDTH-1:0] duty_i,
  // output
  output logic pwm_o
);

  logic [WIDTH-1:0] cnt;
  logic pwm_q;
  wire logic [WIDTH-1:0] next_cnt = cnt + {{(WIDTH-1){1'b0}}, 1'b1};
  wire logic next_pwm = (cnt < duty_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      pwm_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pwm_q <= next_pwm;
    end
  end

  assign pwm_o = pwm_q;

endmodule

//--- core/pps_sequencer.sv
// module: reset, power state and lvds panel control sequencer
`timescale 1ns/100ps
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int BKLT_ON_CYC = BACKLIGHT_ON_DELAY_CYC,
  parameter int BKLT_OFF_CYC = BACKLIGHT_OFF_TO_VIDEO_OFF_DELAY_CYC,
  parameter int PWR_OFF_CYC = VIDEO_OFF_TO_POWER_OFF_DELAY_CYC,
  parameter logic [7:0] CAPABILITY = RST_CAPABILITY
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // aux register port
  input wire logic aux_wr_i,
  input wire logic aux_rd_i,
  input wire logic [19:0] aux_addr_i,
  input wire logic [7:0] aux_wdata_i,
  output logic [7:0] aux_rdata_o,
  output logic aux_rvalid_o,
  // pins and straps
  input wire logic [1:0] bus_role_strap_i,
  input wire logic deep_sleep_req_n_i,
  input wire logic deep_sleep_pin_open_i,
  // video status from the receiver
  input wire logic video_present_i,
  input wire logic video_sync_lost_i,
  input wire logic source_pwm_i,
  // panel and link control
  output logic hot_plug_out_o,
  output logic panel_power_en_o,
  output logic backlight_en_o,
  output logic dimming_pwm_out_o,
  output logic lvds_out_en_o,
  output logic lvds_pulldown_o,
  output logic main_link_hiz_o,
  // i2c configuration
  output logic i2c_en_o,
  output logic i2c_master_o,
  output logic [7:0] i2c_slave_addr_o
);

  pps_state_type state, next_state;
  logic [7:0] power_state_request;
  logic [7:0] panel_display_control;
  logic [7:0] dimming_level;
  logic sink_lock;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic strap_pending;
  logic [1:0] strap_q;
  pps_panel_type panel;
  pps_i2c_type i2c;
  logic [7:0] rdata;
  logic rvalid;
  logic pwm_q;
  logic gen_pwm;

  // aux decode; the port never depends on straps or power state
  wire logic wr_power = aux_wr_i && (aux_addr_i == REG_POWER_STATE_REQUEST);
  wire logic wr_ctrl = aux_wr_i && (aux_addr_i == REG_PANEL_DISPLAY_CONTROL);
  wire logic wr_dim = aux_wr_i && (aux_addr_i == REG_DIMMING_LEVEL);
  wire logic [7:0] lock_word = {7'h00, sink_lock};
  wire logic [7:0] next_rdata =
    (aux_addr_i == REG_SINK_LOCK_STATUS) ? lock_word :
    (aux_addr_i == REG_POWER_STATE_REQUEST) ? power_state_request :
    (aux_addr_i == REG_PANEL_GENERAL_CAPABILITY) ? CAPABILITY :
    (aux_addr_i == REG_PANEL_DISPLAY_CONTROL) ? panel_display_control :
    (aux_addr_i == REG_DIMMING_LEVEL) ? dimming_level : 8'h00;

  // a write in this cycle steers the fsm at once, so look at the new value
  wire logic [7:0] power_now = wr_power ? aux_wdata_i : power_state_request;
  wire logic req_d3 = (power_now == PWR_D3);
  wire logic req_d0 = (power_now == PWR_D0);
  // panel power is gated by the request only if the panel says it obeys it
  wire logic power_allowed = !CAPABILITY[CAP_SET_POWER_BIT] || req_d0;
  wire logic bklt_wanted = !CAPABILITY[CAP_BKLT_PIN_BIT] ||
                           panel_display_control[CTRL_BKLT_EN_BIT];
  wire logic video_ok = video_present_i && !video_sync_lost_i;
  wire logic deep_req = !deep_sleep_req_n_i && !deep_sleep_pin_open_i;
  wire logic timer_done = (timer == '0);

  always_comb begin
    next_state = state;
    if (deep_req) begin
      // abrupt entry: the panel off ordering is skipped here
      next_state = ST_DEEP_SLEEP;
    end else begin
      unique case (state)
        ST_WAIT_VIDEO: begin
          if (req_d3) begin
            next_state = ST_LOW_POWER;
          end else if (video_ok && power_allowed) begin
            next_state = ST_STREAM;
          end
        end
        ST_STREAM: begin
          if (req_d3) begin
            next_state = ST_VIDEO_OFF;
          end else if (!video_ok) begin
            next_state = ST_VIDEO_OFF;
          end else if (timer_done && bklt_wanted) begin
            next_state = ST_LIT;
          end
        end
        ST_LIT: begin
          if (req_d3) begin
            next_state = ST_BKLT_OFF;
          end else if (!video_ok) begin
            next_state = ST_VIDEO_OFF;
          end else if (!bklt_wanted) begin
            next_state = ST_STREAM;
          end
        end
        ST_BKLT_OFF: begin
          if (timer_done) begin
            next_state = ST_VIDEO_OFF;
          end
        end
        ST_VIDEO_OFF: begin
          if (timer_done) begin
            next_state = req_d3 ? ST_LOW_POWER : ST_WAIT_VIDEO;
          end
        end
        ST_LOW_POWER: begin
          if (req_d0) begin
            next_state = ST_WAIT_VIDEO;
          end
        end
        ST_DEEP_SLEEP: begin
          next_state = ST_WAIT_VIDEO;
        end
      endcase
    end
  end

  // delay loaded on entry to each timed state, counted down otherwise
  always_comb begin
    next_timer = timer;
    if (next_state != state) begin
      unique case (next_state)
        ST_STREAM: next_timer = TIMER_W'(BKLT_ON_CYC - 1);
        ST_BKLT_OFF: next_timer = TIMER_W'(BKLT_OFF_CYC - 1);
        ST_VIDEO_OFF: next_timer = TIMER_W'(PWR_OFF_CYC - 1);
        default: next_timer = '0;
      endcase
    end else if (!timer_done) begin
      next_timer = timer - TIMER_W'(1);
    end
  end

  // outputs per state; lvds and power come up together, backlight last
  wire logic in_deep = (next_state == ST_DEEP_SLEEP);
  wire logic in_d3 = (next_state == ST_LOW_POWER);
  wire logic lvds_on = (next_state == ST_STREAM) || (next_state == ST_LIT) ||
                       (next_state == ST_BKLT_OFF);
  wire logic power_on = lvds_on || (next_state == ST_VIDEO_OFF);
  pps_panel_type next_panel;
  assign next_panel.panel_power_en = power_on;
  assign next_panel.backlight_en = (next_state == ST_LIT);
  assign next_panel.lvds_out_en = lvds_on;
  assign next_panel.lvds_pulldown = !lvds_on;
  assign next_panel.main_link_hiz = in_d3 || in_deep;
  assign next_panel.hot_plug_out = !in_deep;

  // strap decode; addressing is fixed until the next sampling point
  pps_i2c_type next_i2c;
  assign next_i2c.i2c_master = (strap_q == STRAP_HIGH);
  assign next_i2c.i2c_addr = (strap_q == STRAP_LOW) ? I2C_ADDR_LOW : I2C_ADDR_HIGH;
  assign next_i2c.i2c_en = !in_d3 && !in_deep;
  wire logic next_pwm = panel_display_control[CTRL_PWM_PASS_BIT] ? source_pwm_i : gen_pwm;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_WAIT_VIDEO;
      timer <= '0;
      panel <= '0;
      i2c <= '0;
      pwm_q <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      panel <= next_panel;
      i2c <= next_i2c;
      pwm_q <= next_pwm;
    end
  end

  // straps are caught by the clock after reset release or deep sleep exit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_pending <= 1'b1;
      strap_q <= STRAP_OPEN;
    end else begin
      strap_pending <= (next_state == ST_DEEP_SLEEP);
      if (strap_pending && !deep_req) begin
        strap_q <= bus_role_strap_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_state_request <= RST_POWER_STATE;
      panel_display_control <= RST_DISPLAY_CONTROL;
      dimming_level <= RST_DIMMING_LEVEL;
      sink_lock <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      if (wr_power) begin
        power_state_request <= aux_wdata_i;
      end
      if (wr_ctrl) begin
        panel_display_control <= aux_wdata_i;
      end
      if (wr_dim) begin
        dimming_level <= aux_wdata_i;
      end
      sink_lock <= lvds_on;
      rdata <= aux_rd_i ? next_rdata : 8'h00;
      rvalid <= aux_rd_i;
    end
  end

  pps_pwm_gen #(
    .WIDTH(PWM_W)
  ) u_pwm (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .duty_i(dimming_level),
    .pwm_o(gen_pwm)
  );

  assign aux_rdata_o = rdata;
  assign aux_rvalid_o = rvalid;
  assign hot_plug_out_o = panel.hot_plug_out;
  assign panel_power_en_o = panel.panel_power_en;
  assign backlight_en_o = panel.backlight_en;
  assign lvds_out_en_o = panel.lvds_out_en;
  assign lvds_pulldown_o = panel.lvds_pulldown;
  assign main_link_hiz_o = panel.main_link_hiz;
  assign dimming_pwm_out_o = pwm_q;
  assign i2c_en_o = i2c.i2c_en;
  assign i2c_master_o = i2c.i2c_master;
  assign i2c_slave_addr_o = i2c.i2c_addr;

  // backlight never on without lvds streaming and panel power
  a_bklt_needs_lvds: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    backlight_en_o |-> (lvds_out_en_o && panel_power_en_o))
    else $error("backlight on without lvds and panel power");

  a_bklt_after_delay: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(lvds_out_en_o) |-> !backlight_en_o [*2])
    else $error("backlight rose too early after lvds start");

  a_d3_bklt_first: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_LIT && wr_power && aux_wdata_i == PWR_D3 && !deep_req) |=>
      (!backlight_en_o && lvds_out_en_o))
    else $error("lvds stopped before backlight on d3 request");

  a_power_off_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_VIDEO_OFF && !timer_done && !deep_req) |=> panel_power_en_o)
    else $error("panel power dropped before off delay");

  a_d3_outputs: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_LOW_POWER) |-> (!panel_power_en_o && !backlight_en_o && lvds_pulldown_o))
    else $error("panel outputs active in low power state");

  a_d3_i2c_off: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_LOW_POWER) |-> (!i2c_en_o && main_link_hiz_o && hot_plug_out_o))
    else $error("low power state pin states wrong");

  a_deep_hpd_low: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    deep_req |=> (!hot_plug_out_o && !backlight_en_o && lvds_pulldown_o))
    else $error("deep sleep outputs wrong");

  a_open_no_deep: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    deep_sleep_pin_open_i |=> (state != ST_DEEP_SLEEP))
    else $error("deep sleep entered with open pin");

  a_d0_wakes: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_LOW_POWER && wr_power && aux_wdata_i == PWR_D0 && !deep_req) |=>
      (state == ST_WAIT_VIDEO) ##1 (i2c_en_o && !main_link_hiz_o))
    else $error("d0 write did not leave low power");

  a_strap_addr: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (strap_q == STRAP_LOW) |=> (i2c_slave_addr_o == I2C_ADDR_LOW))
    else $error("low strap gave wrong i2c address");

endmodule

//--- tb/pps_source_model.sv
// source-side partner: video stream status and source pwm towards the sequencer
`timescale 1ns/100ps
module pps_source_model (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic stream_on_i,
  input wire logic sync_drop_i,
  input wire logic pwm_level_i,
  // status towards the sequencer
  output logic video_present_o,
  output logic video_sync_lost_o,
  output logic source_pwm_o
);
  initial begin
    video_present_o = 1'b0;
    video_sync_lost_o = 1'b0;
    source_pwm_o = 1'b0;
  end
  // the stream stays up until the bench ends it, so it spans both off delays
  always @(negedge clk_i) begin
    video_present_o <= stream_on_i;
    video_sync_lost_o <= sync_drop_i & stream_on_i;
    source_pwm_o <= pwm_level_i;
  end
endmodule

//--- tb/tb_pps_sequencer.sv
// self-checking bench of the panel power sequencer with its source partner
`timescale 1ns/100ps
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))
module tb_pps_sequencer import pps_pkg::*;;
  localparam int ON_CYC = 4;
  localparam int OFF_CYC = 3;
  localparam int PWR_CYC = 5;
  localparam int LIMIT = 200;
  localparam int I_PWR = 6;
  localparam int I_BL = 5;
  localparam int I_LV = 4;
  localparam int I_HP = 1;
  logic clk, rst_n, aux_wr, aux_rd, aux_rvalid, sleep_n, pin_open, vid, lost, spwm;
  logic stream_on, sync_drop, pwm_level, pwm, i2c_en, i2c_master;
  logic [19:0] aux_addr;
  logic [7:0] aux_wdata, aux_rdata, i2c_addr;
  logic [1:0] strap;
  // a net, so that each output port may drive its own field
  wire pps_panel_type pnl;
  wire logic [6:0] outs = {pnl, i2c_en};
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  pps_source_model i_source (.clk_i(clk), .stream_on_i(stream_on), .sync_drop_i(sync_drop),
    .pwm_level_i(pwm_level), .video_present_o(vid), .video_sync_lost_o(lost),
    .source_pwm_o(spwm));

  pps_sequencer #(.BKLT_ON_CYC(ON_CYC), .BKLT_OFF_CYC(OFF_CYC), .PWR_OFF_CYC(PWR_CYC)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .aux_wr_i(aux_wr), .aux_rd_i(aux_rd),
    .aux_addr_i(aux_addr), .aux_wdata_i(aux_wdata), .aux_rdata_o(aux_rdata),
    .aux_rvalid_o(aux_rvalid), .bus_role_strap_i(strap), .deep_sleep_req_n_i(sleep_n),
    .deep_sleep_pin_open_i(pin_open), .video_present_i(vid), .video_sync_lost_i(lost),
    .source_pwm_i(spwm), .hot_plug_out_o(pnl.hot_plug_out),
    .panel_power_en_o(pnl.panel_power_en), .backlight_en_o(pnl.backlight_en),
    .dimming_pwm_out_o(pwm), .lvds_out_en_o(pnl.lvds_out_en),
    .lvds_pulldown_o(pnl.lvds_pulldown), .main_link_hiz_o(pnl.main_link_hiz),
    .i2c_en_o(i2c_en), .i2c_master_o(i2c_master), .i2c_slave_addr_o(i2c_addr));

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // no trailing edge: callers leave a cycle before a second write
  task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
    aux_addr = a;
    aux_wdata = d;
    aux_wr = 1'b1;
    tick(1);
    aux_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [19:0] a, output logic [7:0] d);
    aux_addr = a;
    aux_rd = 1'b1;
    tick(1);
    aux_rd = 1'b0;
    `CHK("read valid", 1'b1, aux_rvalid);
    d = aux_rdata;
    tick(1);
  endtask

  task automatic wait_out(input int idx, input logic v, output int n);
    n = 0;
    while (outs[idx] !== v && n < LIMIT) begin
      tick(1);
      n++;
    end
    `CHK("output reached", 1'b1, n < LIMIT);
  endtask

  task automatic pulse_reset();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(3);
  endtask

  task automatic test_regs();
    logic [7:0] d;
    reg_rd(REG_POWER_STATE_REQUEST, d);
    `CHK("power request reset", RST_POWER_STATE, d);
    reg_rd(REG_DIMMING_LEVEL, d);
    `CHK("dimming reset", RST_DIMMING_LEVEL, d);
    reg_wr(REG_PANEL_GENERAL_CAPABILITY, 8'h00);
    reg_rd(REG_PANEL_GENERAL_CAPABILITY, d);
    `CHK("capability read only", RST_CAPABILITY, d);
    reg_rd(20'h0_0123, d);
    `CHK("unmapped read", 8'h00, d);
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h81);
    pulse_reset();
    reg_rd(REG_PANEL_DISPLAY_CONTROL, d);
    `CHK("control after reset", RST_DISPLAY_CONTROL, d);
    `CHK("hot plug up", 1'b1, pnl.hot_plug_out);
    $display("test_regs done");
  endtask

  task automatic test_straps();
    logic [1:0] code [4] = '{STRAP_LOW, STRAP_OPEN, STRAP_HIGH, 2'h3};
    for (int k = 0; k < 4; k++) begin
      strap = code[k];
      pulse_reset();
      `CHK("slave address", code[k] == STRAP_LOW ? I2C_ADDR_LOW : I2C_ADDR_HIGH, i2c_addr);
      `CHK("master role", code[k] == STRAP_HIGH, i2c_master);
    end
    strap = STRAP_OPEN;
    pulse_reset();
    $display("test_straps done");
  endtask

  task automatic test_power_up();
    int n;
    logic [7:0] d;
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h01);
    stream_on = 1'b1;
    wait_out(I_LV, 1'b1, n);
    `CHK("power with lvds", 1'b1, pnl.panel_power_en);
    `CHK("pulldown released", 1'b0, pnl.lvds_pulldown);
    `CHK("backlight waits", 1'b0, pnl.backlight_en);
    wait_out(I_BL, 1'b1, n);
    `CHK("backlight on delay", ON_CYC, n);
    reg_rd(REG_SINK_LOCK_STATUS, d);
    `CHK("sink lock", 1'b1, d[LOCK_BIT]);
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h00);
    wait_out(I_BL, 1'b0, n);
    `CHK("video kept without backlight", 1'b1, pnl.lvds_out_en);
    `CHK("power kept without backlight", 1'b1, pnl.panel_power_en);
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h01);
    wait_out(I_BL, 1'b1, n);
    // the delay restarts when backlight falls; the write lands one cycle later
    `CHK("backlight re-enabled", ON_CYC - 1, n);
    $display("test_power_up done");
  endtask

  task automatic test_d3();
    int n;
    logic [7:0] d;
    reg_wr(REG_POWER_STATE_REQUEST, PWR_D3);
    wait_out(I_BL, 1'b0, n);
    `CHK("lvds outlives backlight", 1'b1, pnl.lvds_out_en);
    wait_out(I_LV, 1'b0, n);
    `CHK("backlight to video off", OFF_CYC, n);
    wait_out(I_PWR, 1'b0, n);
    `CHK("video off to power off", PWR_CYC, n);
    tick(2);
    `CHK("d3 link hiz", 1'b1, pnl.main_link_hiz);
    `CHK("d3 i2c stopped", 1'b0, i2c_en);
    `CHK("d3 hot plug kept", 1'b1, pnl.hot_plug_out);
    `CHK("d3 pulldown", 1'b1, pnl.lvds_pulldown);
    tick(20);
    `CHK("no power in d3", 1'b0, pnl.panel_power_en);
    reg_rd(REG_POWER_STATE_REQUEST, d);
    `CHK("d3 readback", PWR_D3, d);
    reg_wr(REG_POWER_STATE_REQUEST, PWR_D0);
    wait_out(I_BL, 1'b1, n);
    `CHK("d0 i2c back", 1'b1, i2c_en);
    `CHK("d0 lvds back", 1'b1, pnl.lvds_out_en);
    $display("test_d3 done");
  endtask

  task automatic test_sync_loss();
    int n;
    sync_drop = 1'b1;
    wait_out(I_LV, 1'b0, n);
    `CHK("backlight with lvds", 1'b0, pnl.backlight_en);
    wait_out(I_PWR, 1'b0, n);
    `CHK("sync loss to power off", PWR_CYC, n);
    sync_drop = 1'b0;
    wait_out(I_LV, 1'b1, n);
    `CHK("restart after sync", 1'b1, pnl.panel_power_en);
    stream_on = 1'b0;
    wait_out(I_LV, 1'b0, n);
    wait_out(I_PWR, 1'b0, n);
    `CHK("stream end to power off", PWR_CYC, n);
    $display("test_sync_loss done");
  endtask

  task automatic test_deep_sleep();
    int n;
    pin_open = 1'b1;
    sleep_n = 1'b0;
    tick(10);
    `CHK("open pin no sleep", 1'b1, pnl.hot_plug_out);
    pin_open = 1'b0;
    strap = STRAP_LOW;
    wait_out(I_HP, 1'b0, n);
    `CHK("sleep backlight", 1'b0, pnl.backlight_en);
    `CHK("sleep i2c off", 1'b0, i2c_en);
    tick(10);
    `CHK("stays asleep", 1'b0, pnl.hot_plug_out);
    sleep_n = 1'b1;
    wait_out(I_HP, 1'b1, n);
    tick(2);
    `CHK("strap resampled", I2C_ADDR_LOW, i2c_addr);
    $display("test_deep_sleep done");
  endtask

  task automatic test_pwm();
    int n;
    reg_wr(REG_DIMMING_LEVEL, 8'h40);
    tick(1);
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h00);
    tick(4);
    n = 0;
    repeat (256) begin
      tick(1);
      n += int'(pwm === 1'b1);
    end
    `CHK("own pwm duty", 64, n);
    reg_wr(REG_PANEL_DISPLAY_CONTROL, 8'h80);
    pwm_level = 1'b1;
    tick(4);
    `CHK("pass high", 1'b1, pwm);
    pwm_level = 1'b0;
    tick(4);
    `CHK("pass low", 1'b0, pwm);
    $display("test_pwm done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {aux_wr, aux_rd, pin_open, stream_on, sync_drop, pwm_level} = '0;
    aux_addr = '0;
    aux_wdata = '0;
    sleep_n = 1'b1;
    strap = STRAP_OPEN;
    rst_n = 1'b0;
    tick(12);
    rst_n = 1'b1;
    tick(3);
    test_regs();
    test_straps();
    test_power_up();
    test_d3();
    test_sync_loss();
    test_deep_sleep();
    test_pwm();
    test_done();
  end
endmodule
